//--- dma_channel_setup.v
// One DMA channel: setup registers, progress pointers, block completion and interrupt
`include "dma_chan_map.vh"
`default_nettype none

module dma_channel_setup #(
	parameter AW = 8
) (
	input wire clk,
	input wire rstn,
	// Register port
	input wire [AW-1:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata_r,
	// Byte mover handshake
	output reg xfer_req_r,
	output reg [31:0] src_addr_r,
	output reg [31:0] dst_addr_r,
	input wire xfer_ack,
	// Interrupt
	output reg irq_r
);

	// ============================================================
	// Address decode

	// Compare a bus address against one register offset
	function hit;
		input [AW-1:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs[AW-1:0]);
		end
	endfunction

	wire wr_ctrl;
	wire wr_src_start;
	wire wr_dst_start;
	wire wr_src_size;
	wire wr_dst_size;
	wire wr_mask;
	wire rd_stat;

	assign wr_ctrl = wr && hit(addr, `OFS_CTRL);
	assign wr_src_start = wr && hit(addr, `OFS_SRC_START);
	assign wr_dst_start = wr && hit(addr, `OFS_DST_START);
	assign wr_src_size = wr && hit(addr, `OFS_SRC_SIZE);
	assign wr_dst_size = wr && hit(addr, `OFS_DST_SIZE);
	assign wr_mask = wr && hit(addr, `OFS_INT_MASK);
	assign rd_stat = rd && hit(addr, `OFS_INT_STAT);

	// ============================================================
	// Setup registers

	reg [31:0] src_start_addr_field_r;
	reg [31:0] dst_start_addr_field_r;
	reg [15:0] src_size_field_r;
	reg [15:0] dst_size_field_r;
	reg [`INT_WIDTH-1:0] int_mask_r;

	// Only software writes land here; the engine never touches them
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			src_start_addr_field_r <= `RST_ADDR;
			dst_start_addr_field_r <= `RST_ADDR;
			src_size_field_r <= `RST_SIZE;
			dst_size_field_r <= `RST_SIZE;
			int_mask_r <= `RST_MASK;
		end else begin
			if (wr_src_start) begin
				src_start_addr_field_r <= wdata;
			end
			if (wr_dst_start) begin
				dst_start_addr_field_r <= wdata;
			end
			if (wr_src_size) begin
				src_size_field_r <= wdata[15:0];
			end
			if (wr_dst_size) begin
				dst_size_field_r <= wdata[15:0];
			end
			if (wr_mask) begin
				int_mask_r <= wdata[`INT_WIDTH-1:0];
			end
		end
	end

	// ============================================================
	// Channel state

	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [16:0] moved_r;
	reg [16:0] moved_nxt;
	reg ptr_clear;
	reg block_evt;
	reg abort_evt;

	wire en_set;
	wire abort_req;
	wire step;
	wire [15:0] src_pointer;
	wire [15:0] dst_pointer;
	wire [16:0] src_bytes;
	wire [16:0] dst_bytes;
	wire [16:0] block_bytes;
	wire [16:0] moved_inc;
	wire src_done_flag;
	wire src_half_empty_flag;
	wire dst_done_evt;
	wire dst_half_evt;

	assign en_set = wr_ctrl && wdata[`CTRL_EN_BIT];
	assign abort_req = wr_ctrl && (wdata[`CTRL_ABORT_BIT] || !wdata[`CTRL_EN_BIT]);
	// A byte counts only while running and offered
	assign step = (state_r == ST_RUN) && xfer_req_r && xfer_ack;
	// Block length is the larger of the two decoded sizes
	assign block_bytes = (src_bytes > dst_bytes) ? src_bytes : dst_bytes;
	assign moved_inc = moved_r + 17'h0_0001;

	// Next state: start, count bytes, finish the block or stop on abort
	always @* begin
		state_nxt = state_r;
		moved_nxt = moved_r;
		ptr_clear = 1'b0;
		block_evt = 1'b0;
		abort_evt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (en_set && !wdata[`CTRL_ABORT_BIT]) begin
					state_nxt = ST_RUN;
					moved_nxt = 17'h0_0000;
					ptr_clear = 1'b1;
				end
			end
			ST_RUN: begin
				if (abort_req) begin
					state_nxt = ST_IDLE;
					ptr_clear = 1'b1;
					abort_evt = 1'b1;
				end else if (step) begin
					if (moved_inc == block_bytes) begin
						state_nxt = ST_IDLE;
						moved_nxt = 17'h0_0000;
						ptr_clear = 1'b1;
						block_evt = 1'b1;
					end else begin
						moved_nxt = moved_inc;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				moved_nxt = 17'h0_0000;
				ptr_clear = 1'b1;
			end
		endcase
	end

	// State and byte count registers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			moved_r <= 17'h0_0000;
		end else begin
			state_r <= state_nxt;
			moved_r <= moved_nxt;
		end
	end

	// ============================================================
	// Source and destination pointers

	// Pointers run from zero and offset the start addresses, never rewrite them
	byte_pointer #(
		.W(16)
	) u_src_ptr (
		.clk(clk),
		.rstn(rstn),
		.clear(ptr_clear),
		.step(step),
		.size_field(src_size_field_r),
		.ptr_r(src_pointer),
		.done_r(src_done_flag),
		.half_r(src_half_empty_flag),
		.size_bytes(src_bytes)
	);

	byte_pointer #(
		.W(16)
	) u_dst_ptr (
		.clk(clk),
		.rstn(rstn),
		.clear(ptr_clear),
		.step(step),
		.size_field(dst_size_field_r),
		.ptr_r(dst_pointer),
		.done_r(dst_done_evt),
		.half_r(dst_half_evt),
		.size_bytes(dst_bytes)
	);

	// ============================================================
	// Byte mover handshake

	// Request drops for a cycle after each byte so the addresses settle
	// before the next one is offered; half the peak rate, but no stale address.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			xfer_req_r <= 1'b0;
			src_addr_r <= `RST_ADDR;
			dst_addr_r <= `RST_ADDR;
		end else begin
			xfer_req_r <= (state_nxt == ST_RUN) && !step && !ptr_clear;
			src_addr_r <= src_start_addr_field_r + {16'h0000, src_pointer};
			dst_addr_r <= dst_start_addr_field_r + {16'h0000, dst_pointer};
		end
	end

	// ============================================================
	// Interrupt

	wire [`INT_WIDTH-1:0] int_events;
	wire [`INT_WIDTH-1:0] int_status;
	wire irq_level;

	assign int_events = {abort_evt, dst_half_evt, dst_done_evt,
		src_half_empty_flag, src_done_flag, block_evt};

	irq_status #(
		.N(`INT_WIDTH)
	) u_irq (
		.clk(clk),
		.rstn(rstn),
		.events(int_events),
		.rd_clear(rd_stat),
		.mask(int_mask_r),
		.status_r(int_status),
		.irq_r(irq_level)
	);

	// Top output kept as its own flop; follows the status one cycle later
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_level;
		end
	end

	// ============================================================
	// Read path

	reg [31:0] rdata_nxt;

	// Unmapped offsets and unimplemented bits read zero
	always @* begin
		rdata_nxt = 32'h0000_0000;
		if (hit(addr, `OFS_CTRL)) begin
			rdata_nxt[`CTRL_EN_BIT] = (state_r == ST_RUN);
			rdata_nxt[`CTRL_BUSY_BIT] = (state_r == ST_RUN);
		end else if (hit(addr, `OFS_SRC_START)) begin
			rdata_nxt = src_start_addr_field_r;
		end else if (hit(addr, `OFS_DST_START)) begin
			rdata_nxt = dst_start_addr_field_r;
		end else if (hit(addr, `OFS_SRC_SIZE)) begin
			rdata_nxt = {16'h0000, src_size_field_r};
		end else if (hit(addr, `OFS_DST_SIZE)) begin
			rdata_nxt = {16'h0000, dst_size_field_r};
		end else if (hit(addr, `OFS_SRC_PTR)) begin
			rdata_nxt = {16'h0000, src_pointer};
		end else if (hit(addr, `OFS_DST_PTR)) begin
			rdata_nxt = {16'h0000, dst_pointer};
		end else if (hit(addr, `OFS_INT_STAT)) begin
			rdata_nxt = {26'h000_0000, int_status};
		end else if (hit(addr, `OFS_INT_MASK)) begin
			rdata_nxt = {26'h000_0000, int_mask_r};
		end
	end

	// Data stand only in the cycle after the read strobe
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= 32'h0000_0000;
		end else if (rd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

endmodule // dma_channel_setup

`default_nettype wire

//--- dma_chan_map.vh
// Register map, field positions and reset values of one DMA channel setup block
//
// Summary of operation
// - Source start address is a 32-bit read/write register, zero after power-on reset.
// - Destination start address is a 32-bit read/write register, zero after reset.
// - Source size field occupies bits 15..0, read/write, resets to zero.
// - Source size bits 31..16 are unimplemented and always read zero.
// - A nonzero source size N means a source buffer of exactly N bytes.
// - A source size of zero means a source buffer of 65,536 bytes.
// - Block completes after the larger of source and destination sizes is moved.
// - Source done flag at pointer equal size, half flag at half size.
// - Destination size uses the same encoding, zero meaning 65,536 bytes.
`ifndef DMA_CHAN_MAP_VH
`define DMA_CHAN_MAP_VH

// ============================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SRC_START 8'h04
`define OFS_DST_START 8'h08
`define OFS_SRC_SIZE 8'h0C
`define OFS_DST_SIZE 8'h10
`define OFS_SRC_PTR 8'h14
`define OFS_DST_PTR 8'h18
`define OFS_INT_STAT 8'h1C
`define OFS_INT_MASK 8'h20

// ============================================================
// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_ABORT_BIT 1
`define CTRL_BUSY_BIT 2

// ============================================================
// Interrupt status and mask fields
`define INT_BLOCK_BIT 0
`define INT_SRC_DONE_BIT 1
`define INT_SRC_HALF_BIT 2
`define INT_DST_DONE_BIT 3
`define INT_DST_HALF_BIT 4
`define INT_ABORT_BIT 5
`define INT_WIDTH 6

// ============================================================
// Reset values and size encoding
`define RST_ADDR 32'h0000_0000
`define RST_SIZE 16'h0000
`define RST_MASK 6'h00
`define SIZE_FIELD_W 16
`define SIZE_MAX_BYTES 17'h1_0000

`endif

//--- byte_pointer.v
// Byte pointer of one side of a channel, with done and half-way events
`default_nettype none

module byte_pointer #(
	parameter W = 16
) (
	input wire clk,
	input wire rstn,
	input wire clear,
	input wire step,
	input wire [W-1:0] size_field,
	output reg [W-1:0] ptr_r,
	output reg done_r,
	output reg half_r,
	output wire [W:0] size_bytes
);

	// Zero in the size field stands for the largest buffer
	function [W:0] decode_size;
		input [W-1:0] f;
		begin
			if (f == {W{1'b0}}) begin
				decode_size = {1'b1, {W{1'b0}}};
			end else begin
				decode_size = {1'b0, f};
			end
		end
	endfunction

	wire [W:0] ptr_inc;

	assign size_bytes = decode_size(size_field);
	assign ptr_inc = {1'b0, ptr_r} + {{W{1'b0}}, 1'b1};

	// Pointer advances per byte and wraps at the buffer end; events are one-cycle pulses
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ptr_r <= {W{1'b0}};
			done_r <= 1'b0;
			half_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			half_r <= 1'b0;
			if (clear) begin
				ptr_r <= {W{1'b0}};
			end else if (step && (ptr_inc == size_bytes)) begin
				ptr_r <= {W{1'b0}};
			end else if (step) begin
				ptr_r <= ptr_inc[W-1:0];
			end
			// Events follow the step alone: the block's last byte also clears the
			// pointer, and its done mark must not be lost to that clear
			if (step && (ptr_inc == size_bytes)) begin
				done_r <= 1'b1;
			end
			// Half mark; a one-byte buffer has none
			if (step && (ptr_inc == (size_bytes >> 1))) begin
				half_r <= 1'b1;
			end
		end
	end

endmodule // byte_pointer

`default_nettype wire

//--- irq_status.v
// Sticky interrupt status with read-clear, mask and one level output
`default_nettype none

module irq_status #(
	parameter N = 6
) (
	input wire clk,
	input wire rstn,
	input wire [N-1:0] events,
	input wire rd_clear,
	input wire [N-1:0] mask,
	output reg [N-1:0] status_r,
	output reg irq_r
);

	wire [N-1:0] status_nxt;

	// A new event in the clearing cycle survives the clear
	assign status_nxt = (rd_clear ? {N{1'b0}} : status_r) | events;

	// Status bits and interrupt level follow each other in the same cycle
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_r <= {N{1'b0}};
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_r <= |(status_nxt & mask);
		end
	end

endmodule // irq_status

`default_nettype wire

//--- dma_channel_setup_monitor.sv
// Assertion checker for the DMA channel setup block
`default_nettype none
module chan_monitor #(
	parameter AW = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [AW-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata_r,
	input wire logic xfer_req_r,
	input wire logic [31:0] src_addr_r,
	input wire logic [31:0] dst_addr_r,
	input wire logic xfer_ack,
	input wire logic irq_r
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] since_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Cycles since the last ack or write, saturating so old events age out
	always @(posedge clk or negedge rstn) begin
		if (!rstn) since_r <= 3'h7;
		else if (xfer_ack || wr) since_r <= 3'h0;
		else if (since_r != 3'h7) since_r <= since_r + 3'h1;
	end
	// ============================================================
	// Register port and mover handshake
	a_rdata_idle: assert property (!$past(rd) |-> rdata_r == 32'h0)
		else $error("read data outside read slot");
	a_ack_drop: assert property (xfer_req_r && xfer_ack |=> !xfer_req_r)
		else $error("request held after ack");
	a_req_hold: assert property (xfer_req_r && !xfer_ack && !wr |=> xfer_req_r)
		else $error("request dropped without ack");
	a_req_rise: assert property ($rose(xfer_req_r) |-> $past(xfer_ack, 2) || $past(wr, 2))
		else $error("request rose without cause");
	a_addr_steady: assert property (xfer_req_r && $past(xfer_req_r) |->
		$stable(src_addr_r) && $stable(dst_addr_r)) else $error("address moved under request");
	a_addr_move: assert property ($changed(src_addr_r) || $changed(dst_addr_r) |->
		$past(xfer_ack, 2) || $past(wr) || $past(wr, 2) || $past(wr, 3))
		else $error("address moved without ack or write");
	// ============================================================
	// Interrupt output
	a_irq_cause: assert property ($rose(irq_r) |-> since_r <= 3'h4)
		else $error("interrupt without event");
	a_irq_clear: assert property ($fell(irq_r) |-> $past(rd, 2) || $past(rd, 3) ||
		$past(wr, 2) || $past(wr, 3)) else $error("interrupt fell without read or mask");
endmodule // chan_monitor
bind dma_channel_setup chan_monitor #(.AW(AW)) u_mon (.clk(clk), .rstn(rstn), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .xfer_req_r(xfer_req_r),
	.src_addr_r(src_addr_r), .dst_addr_r(dst_addr_r), .xfer_ack(xfer_ack), .irq_r(irq_r));
`default_nettype wire

//--- mover_model.sv
// Byte mover model answering the channel's transfer requests
`default_nettype none
module mover_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic xfer_req_r,
	input wire logic [3:0] stall,
	output var logic xfer_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_r;
	// One byte per ack after a chosen stall; a dropped request restarts the wait
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_r <= 4'h0;
			xfer_ack <= 1'b0;
		end else begin
			xfer_ack <= 1'b0;
			wait_r <= 4'h0;
			if (xfer_req_r && !xfer_ack) begin
				if (wait_r >= stall) xfer_ack <= 1'b1;
				else wait_r <= wait_r + 4'h1;
			end
		end
	end
endmodule // mover_model
`default_nettype wire

//--- tb_dma_channel_setup.sv
// Testbench for the DMA channel setup block
`default_nettype none
module tb_dma_channel_setup;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata_r, src_addr_r, dst_addr_r;
	logic xfer_req_r, xfer_ack, irq_r;
	logic [3:0] stall = 4'h0;
	int errors = 0, check_count = 0;
	dma_channel_setup #(.AW(8)) u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_r(rdata_r), .xfer_req_r(xfer_req_r), .src_addr_r(src_addr_r),
		.dst_addr_r(dst_addr_r), .xfer_ack(xfer_ack), .irq_r(irq_r));
	mover_model u_mover (.clk(clk), .rstn(rstn), .xfer_req_r(xfer_req_r), .stall(stall),
		.xfer_ack(xfer_ack));
	// 250 MHz clock
	initial forever #2 clk = ~clk;
	// ============================================================
	// Bus and compare helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so look there
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata_r, exp);
	endtask
	// Each accepted byte must carry start plus wrapped offset
	task automatic run_bytes(input int n, input logic [31:0] sa, da, input int ss, ds);
		int i, t;
		i = 0;
		t = 0;
		while (i < n && t < 400) begin
			@(negedge clk);
			t++;
			if (xfer_req_r === 1'b1 && xfer_ack === 1'b1) begin
				chk(src_addr_r, sa + i % ss);
				chk(dst_addr_r, da + i % ds);
				i++;
			end
		end
		chk(i, n);
	endtask
	// ============================================================
	// Scenarios
	task automatic t_regs;
		rd_chk(8'h04, 32'h0);
		rd_chk(8'h08, 32'h0);
		rd_chk(8'h0C, 32'h0);
		wr_reg(8'h04, 32'hFFFF_FFFF);
		rd_chk(8'h04, 32'hFFFF_FFFF);
		wr_reg(8'h08, 32'h8000_0001);
		rd_chk(8'h08, 32'h8000_0001);
		wr_reg(8'h0C, 32'hFFFF_1234);
		rd_chk(8'h0C, 32'h0000_1234);
		rd_chk(8'h3C, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_block;
		wr_reg(8'h04, 32'h2000_0100);
		wr_reg(8'h08, 32'h2000_0800);
		wr_reg(8'h0C, 32'h3);
		wr_reg(8'h10, 32'h5);
		wr_reg(8'h00, 32'h1);
		run_bytes(5, 32'h2000_0100, 32'h2000_0800, 3, 5);
		repeat (6) @(posedge clk);
		#1 chk({xfer_req_r, irq_r}, 32'h0);
		rd_chk(8'h04, 32'h2000_0100);
		rd_chk(8'h0C, 32'h3);
		rd_chk(8'h14, 32'h0);
		wr_reg(8'h20, 32'h3F);
		repeat (3) @(posedge clk);
		#1 chk(irq_r, 32'h1);
		rd_chk(8'h1C, 32'h1F);
		repeat (3) @(posedge clk);
		#1 chk(irq_r, 32'h0);
		$display("t_block done");
	endtask
	// Zero size must act as the largest buffer: no source wrap or events
	task automatic t_big;
		stall <= 4'h6;
		wr_reg(8'h0C, 32'h0);
		wr_reg(8'h10, 32'h2);
		wr_reg(8'h00, 32'h1);
		run_bytes(4, 32'h2000_0100, 32'h2000_0800, 65536, 2);
		rd_chk(8'h14, 32'h4);
		rd_chk(8'h18, 32'h0);
		rd_chk(8'h00, 32'h5);
		wr_reg(8'h00, 32'h0);
		repeat (4) @(posedge clk);
		#1 chk(xfer_req_r, 32'h0);
		chk(irq_r, 32'h1);
		rd_chk(8'h1C, 32'h38);
		rd_chk(8'h14, 32'h0);
		rd_chk(8'h10, 32'h2);
		rd_chk(8'h20, 32'h3F);
		rd_chk(8'h00, 32'h0);
		$display("t_big done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Main sequence after twelve cycles of reset
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_regs;
		t_block;
		t_big;
		report_and_stop;
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		report_and_stop;
	end
endmodule // tb_dma_channel_setup
`default_nettype wire
